// file: mrsc_consts.svh
// What this block does
// RL1 - power-on reset loads program counter with zero
// RL2 - power-on presets port data, direction to ones
// RL3 - qualified long low supply forces full reset
// RL4 - four legal threshold codes select four voltages
// RL5 - illegal threshold code: slow-clock delayed reset, restore
// RL6 - supply reset after slow delay keeps threshold
// RL7 - threshold register powers up as 01010101
// RL8 - supply monitoring off during power-down only
// RL9 - brown-out flag set by hardware, software clears
// RL10 - bad threshold flag set, software zero clears
// RL11 - cause register bits 6 to 3 read zero
// RL12 - normal watchdog time-out: full reset, timeout flag
// RL13 - sleep watchdog time-out clears only pc, sp
// RL14 - timeout, power-down flags follow reset source table
// RL15 - power-on reset disables every interrupt
// RL16 - power-on reset clears watchdog, then it counts
// RL17 - power-on reset switches all timers off
// RL18 - power-on reset points stack at top
// RL19 - ports inputs, eight analogue pins as converter inputs
// RL20 - hold internal reset short delay after power-up
// RL21 - illegal watchdog code: delayed reset, set flag
// RL22 - watchdog code flag cleared only by software
// RL23 - one combined reset, release synchronised to clock
// RL24 - illegal-code delay counted on slow oscillator edges
`ifndef MRSC_CONSTS_SVH
`define MRSC_CONSTS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define MRSC_ADDR_THRESHOLD 4'h0
`define MRSC_ADDR_CAUSE     4'h4
`define MRSC_ADDR_STATUS    4'h8
`define MRSC_ADDR_WDOG      4'hc

// ****************************************************************
// reset values and legal codes
// ****************************************************************
`define MRSC_THR_POR        8'h55
`define MRSC_THR_2V10       8'h55
`define MRSC_THR_2V55       8'h33
`define MRSC_THR_3V15       8'h99
`define MRSC_THR_3V80       8'haa
`define MRSC_WDE_POR        5'h0a
`define MRSC_WDE_ENABLE     5'h0a
`define MRSC_WDE_DISABLE    5'h15
`define MRSC_PORT_POR       8'hff
`define MRSC_ANALOG_POR     8'hff

// ****************************************************************
// field positions
// ****************************************************************
`define MRSC_CAUSE_SYSKEEP  7
`define MRSC_CAUSE_BROWN    2
`define MRSC_CAUSE_BADTHR   1
`define MRSC_CAUSE_BADWDG   0
`define MRSC_STATUS_TO      1
`define MRSC_STATUS_PDF     0

// ****************************************************************
// timing
// ****************************************************************
`define MRSC_CLK_PERIOD_NS     10
`define MRSC_POR_DELAY_NS      1000
`define MRSC_POR_DELAY_CYC     ((`MRSC_POR_DELAY_NS + `MRSC_CLK_PERIOD_NS - 1) / `MRSC_CLK_PERIOD_NS)
`define MRSC_LOW_SUPPLY_MIN_NS 120000
`define MRSC_LOW_SUPPLY_MIN_CYC \
  ((`MRSC_LOW_SUPPLY_MIN_NS + `MRSC_CLK_PERIOD_NS - 1) / `MRSC_CLK_PERIOD_NS)
`define MRSC_SLOW_EDGES        2'h3

`endif

// file: mrsc_pkg.sv
package mrsc_pkg;
  // sequencer states, one-hot
  typedef enum logic [2:0] {
    st_hold = 3'b001,  // internal reset asserted
    st_run  = 3'b010,  // core running
    st_wait = 3'b100   // counting slow-clock edges before reset
  } mrsc_state_t;
endpackage : mrsc_pkg

// file: mrsc_reset_ctrl.sv
`timescale 1ns/10ps
`include "mrsc_consts.svh"

module mrsc_reset_ctrl #(
  parameter int unsigned LOW_SUPPLY_MIN_CYCLES = `MRSC_LOW_SUPPLY_MIN_CYC
) (
  input  wire logic        sys_clk_in,             // 100 MHz system clock
  input  wire logic        rstn_in,                // power-on reset, async
  input  wire logic        slow_osc_in,            // low-speed oscillator
  input  wire logic        low_supply_in,          // detector: supply low
  input  wire logic        wdt_timeout_in,         // watchdog overflow pulse
  input  wire logic        sleep_in,               // core in sleep
  input  wire logic        idle_in,                // core in idle
  input  wire logic        powerdown_in,           // core in power-down
  input  wire logic [3:0]  address_in,             // avalon byte address
  input  wire logic        read_in,
  input  wire logic        write_in,
  input  wire logic [31:0] writedata_in,
  input  wire logic [3:0]  byteenable_in,
  output logic      [31:0] readdata_out,
  output logic             waitrequest_out,
  output logic             core_rst_n_out,         // combined core reset
  output logic             por_init_out,           // power-on init phase
  output logic             pc_sp_clear_out,        // light reset pulse
  output logic             wdt_clear_out,          // watchdog counter clear
  output logic [7:0]       port_init_out,          // port data/dir preset
  output logic [7:0]       analog_assign_out,      // analogue pin assign
  output logic             brownout_monitor_en_out,
  output logic [7:0]       threshold_select_out,
  output logic [4:0]       watchdog_enable_out,
  output logic             idle_sysclk_keep_out,
  output logic             timeout_status_flag_out,
  output logic             powerdown_status_flag_out
);

  // ****************************************************************
  // synchronisers
  // ****************************************************************
  logic        rst_meta;       // release synchroniser, first stage
  logic        rst_sync;       // release synchroniser, second stage
  logic        osc_meta;       // slow clock sampler, first stage
  logic        osc_sync;       // slow clock sampler, second stage
  logic        osc_prev;       // for edge detection
  logic        sup_meta;       // supply detector, first stage
  logic        sup_sync;       // supply detector, second stage

  // deassertion of the pin is asynchronous; only rst_sync is used
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;  // RL23
    end
  end

  // slow oscillator is treated as data, not as a clock
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      osc_prev <= 1'b0;
    end else begin
      osc_meta <= slow_osc_in;
      osc_sync <= osc_meta;
      osc_prev <= osc_sync;
    end
  end

  // analogue detector output arrives from outside the clock domain
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sup_meta <= 1'b0;
      sup_sync <= 1'b0;
    end else begin
      sup_meta <= low_supply_in;
      sup_sync <= sup_meta;
    end
  end

  // ****************************************************************
  // declarations
  // ****************************************************************
  mrsc_pkg::mrsc_state_t state;       // sequencer state
  mrsc_pkg::mrsc_state_t next_state;  // combinational next state
  logic [1:0]  edge_count;            // slow edges seen while waiting
  logic [7:0]  hold_count;            // cycles spent in hold
  logic [16:0] sup_count;             // low-supply duration counter
  logic        pend_lvr;              // latched causes for the reset
  logic        pend_thr;
  logic        pend_wdg;
  logic        por_phase;             // first hold after power-up
  logic        cause_brown;           // sticky cause flags
  logic        cause_badthr;
  logic        cause_badwdg;
  logic        osc_rise;              // slow clock rising edge
  logic        lvr_hit;               // qualified low supply
  logic        thr_legal;             // threshold code is defined
  logic        wdg_legal;             // watchdog code is defined
  logic        trouble;               // any delayed-reset cause
  logic        wait_done;             // last slow edge reached
  logic        hold_done;             // reset delay elapsed
  logic        wdt_full;              // watchdog time-out, running
  logic        wdt_light;             // watchdog time-out, sleeping
  logic        wr_do;                 // write accepted this edge
  logic        wr_lane0;              // write touches the low byte
  logic [7:0]  next_rdata;            // read mux

  assign osc_rise  = osc_sync & ~osc_prev;
  assign lvr_hit   = (sup_count == 17'(LOW_SUPPLY_MIN_CYCLES));
  assign trouble   = lvr_hit | ~thr_legal | ~wdg_legal;
  assign wait_done = (state == mrsc_pkg::st_wait) & osc_rise
                     & (edge_count == `MRSC_SLOW_EDGES - 2'h1);  // RL24
  assign hold_done = (state == mrsc_pkg::st_hold)
                     & (hold_count == 8'(`MRSC_POR_DELAY_CYC - 1));
  assign wdt_full  = (state == mrsc_pkg::st_run) & wdt_timeout_in
                     & ~(sleep_in | idle_in);
  assign wdt_light = (state == mrsc_pkg::st_run) & wdt_timeout_in
                     & (sleep_in | idle_in);
  assign wr_do     = write_in & ~waitrequest_out;
  assign wr_lane0  = wr_do & byteenable_in[0];

  // ****************************************************************
  // code checks
  // ****************************************************************
  // only four threshold codes are defined; all others trip a reset
  always_comb begin
    unique case (threshold_select_out)
      `MRSC_THR_2V10, `MRSC_THR_2V55,
      `MRSC_THR_3V15, `MRSC_THR_3V80: thr_legal = 1'b1;  // RL4
      default:                        thr_legal = 1'b0;
    endcase
  end

  // watchdog field is legal only as enable or disable code
  always_comb begin
    wdg_legal = (watchdog_enable_out == `MRSC_WDE_ENABLE)
              | (watchdog_enable_out == `MRSC_WDE_DISABLE);  // RL21
  end

  // ****************************************************************
  // low supply qualification
  // ****************************************************************
  // a low pulse shorter than the minimum restarts the count, so it
  // never reaches the hit value; power-down keeps the monitor idle
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sup_count <= 17'h0_0000;
    end else if (!sup_sync || powerdown_in) begin
      sup_count <= 17'h0_0000;  // RL3 RL8
    end else if (!lvr_hit) begin
      sup_count <= sup_count + 17'h0_0001;
    end
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  // watchdog time-outs act at once; code faults and low supply wait
  // for slow-clock edges, so the delay spans two to three periods
  always_comb begin
    next_state = state;
    unique case (state)
      mrsc_pkg::st_hold: begin
        if (hold_done && rst_sync) begin
          next_state = mrsc_pkg::st_run;  // RL20 RL23
        end
      end
      mrsc_pkg::st_run: begin
        if (wdt_full) begin
          next_state = mrsc_pkg::st_hold;  // RL12
        end else if (trouble && !wdt_light) begin
          next_state = mrsc_pkg::st_wait;  // RL5 RL6 RL21
        end
      end
      mrsc_pkg::st_wait: begin
        if (wait_done) begin
          next_state = mrsc_pkg::st_hold;
        end
      end
      default: next_state = mrsc_pkg::st_hold;
    endcase
  end

  // state register and the counters that belong to it
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state      <= mrsc_pkg::st_hold;
      edge_count <= 2'h0;
      hold_count <= 8'h00;
    end else begin
      state <= next_state;
      // slow edges count only while waiting
      if (state == mrsc_pkg::st_wait && osc_rise) begin
        edge_count <= edge_count + 2'h1;  // RL24
      end else if (state != mrsc_pkg::st_wait) begin
        edge_count <= 2'h0;
      end
      // hold count restarts on every entry to hold
      if (state != mrsc_pkg::st_hold) begin
        hold_count <= 8'h00;
      end else if (!hold_done) begin
        hold_count <= hold_count + 8'h01;
      end
    end
  end

  // causes gather while waiting, so a second fault is not lost
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pend_lvr <= 1'b0;
      pend_thr <= 1'b0;
      pend_wdg <= 1'b0;
    end else if (state == mrsc_pkg::st_wait || next_state == mrsc_pkg::st_wait) begin
      pend_lvr <= pend_lvr | lvr_hit;
      pend_thr <= pend_thr | ~thr_legal;
      pend_wdg <= pend_wdg | ~wdg_legal;
    end else begin
      pend_lvr <= 1'b0;
      pend_thr <= 1'b0;
      pend_wdg <= 1'b0;
    end
  end

  // ****************************************************************
  // reset outputs
  // ****************************************************************
  // power-on phase lasts until the first hold completes
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      por_phase <= 1'b1;
    end else if (hold_done && rst_sync) begin
      por_phase <= 1'b0;  // RL20
    end
  end

  // every output is a flop so the core sees no glitches
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      core_rst_n_out    <= 1'b0;
      por_init_out      <= 1'b1;
      pc_sp_clear_out   <= 1'b0;
      wdt_clear_out     <= 1'b1;
      port_init_out     <= `MRSC_PORT_POR;
      analog_assign_out <= `MRSC_ANALOG_POR;
    end else begin
      // core restarts from address zero when this rises
      core_rst_n_out    <= (next_state != mrsc_pkg::st_hold);  // RL1 RL23
      // core disables interrupts, stops timers, sets stack top
      por_init_out      <= por_phase;  // RL15 RL17 RL18
      pc_sp_clear_out   <= wdt_light;  // RL13
      // watchdog runs again the cycle after hold ends
      wdt_clear_out     <= (next_state == mrsc_pkg::st_hold);  // RL16
      port_init_out     <= por_phase ? `MRSC_PORT_POR : 8'h00;  // RL2 RL19
      analog_assign_out <= por_phase ? `MRSC_ANALOG_POR : 8'h00;  // RL19
    end
  end

  // monitor enable follows power-down state
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      brownout_monitor_en_out <= 1'b1;
    end else begin
      brownout_monitor_en_out <= ~powerdown_in;  // RL8
    end
  end

  // ****************************************************************
  // status flags
  // ****************************************************************
  // low-supply and code resets leave both flags alone
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      timeout_status_flag_out   <= 1'b0;  // RL14
      powerdown_status_flag_out <= 1'b0;
    end else if (wdt_full) begin
      timeout_status_flag_out   <= 1'b1;  // RL12 RL14
    end else if (wdt_light) begin
      timeout_status_flag_out   <= 1'b1;  // RL13 RL14
      powerdown_status_flag_out <= 1'b1;
    end
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  // a bad code is replaced by its power-on value as the reset fires;
  // a low-supply reset leaves a legal code untouched
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      threshold_select_out <= `MRSC_THR_POR;  // RL7
    end else if (wait_done && pend_thr) begin
      threshold_select_out <= `MRSC_THR_POR;  // RL5
    end else if (wr_lane0 && address_in == `MRSC_ADDR_THRESHOLD) begin
      threshold_select_out <= writedata_in[7:0];
    end
  end

  // watchdog field returns to its default on every full reset
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      watchdog_enable_out <= `MRSC_WDE_POR;
    end else if (wait_done || wdt_full) begin
      watchdog_enable_out <= `MRSC_WDE_POR;
    end else if (wr_lane0 && address_in == `MRSC_ADDR_WDOG) begin
      watchdog_enable_out <= writedata_in[4:0];
    end
  end

  // system clock keep bit is plain read/write
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      idle_sysclk_keep_out <= 1'b0;
    end else if (wr_lane0 && address_in == `MRSC_ADDR_CAUSE) begin
      idle_sysclk_keep_out <= writedata_in[`MRSC_CAUSE_SYSKEEP];
    end
  end

  // ****************************************************************
  // cause flags
  // ****************************************************************
  // hardware only sets; a written zero clears; set beats clear
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cause_brown  <= 1'b0;
      cause_badthr <= 1'b0;
      cause_badwdg <= 1'b0;
    end else begin
      if (wait_done && pend_lvr) begin
        cause_brown <= 1'b1;  // RL3 RL9
      end else if (wr_lane0 && address_in == `MRSC_ADDR_CAUSE
                   && !writedata_in[`MRSC_CAUSE_BROWN]) begin
        cause_brown <= 1'b0;  // RL9
      end
      if (wait_done && pend_thr) begin
        cause_badthr <= 1'b1;  // RL10
      end else if (wr_lane0 && address_in == `MRSC_ADDR_CAUSE
                   && !writedata_in[`MRSC_CAUSE_BADTHR]) begin
        cause_badthr <= 1'b0;  // RL10
      end
      if (wait_done && pend_wdg) begin
        cause_badwdg <= 1'b1;  // RL21
      end else if (wr_lane0 && address_in == `MRSC_ADDR_CAUSE
                   && !writedata_in[`MRSC_CAUSE_BADWDG]) begin
        cause_badwdg <= 1'b0;  // RL22
      end
    end
  end

  // ****************************************************************
  // avalon slave
  // ****************************************************************
  // read mux; unmapped offsets read zero
  always_comb begin
    next_rdata = 8'h00;
    unique case (address_in)
      `MRSC_ADDR_THRESHOLD: next_rdata = threshold_select_out;
      `MRSC_ADDR_CAUSE: begin
        next_rdata = {idle_sysclk_keep_out, 4'h0, cause_brown,
                      cause_badthr, cause_badwdg};  // RL11
      end
      `MRSC_ADDR_STATUS: begin
        next_rdata = {6'h00, timeout_status_flag_out, powerdown_status_flag_out};
      end
      `MRSC_ADDR_WDOG: next_rdata = {3'h0, watchdog_enable_out};
      default:         next_rdata = 8'h00;
    endcase
  end

  // one wait cycle per request keeps waitrequest a plain flop
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      waitrequest_out <= 1'b1;
    end else begin
      waitrequest_out <= ~((read_in | write_in) & waitrequest_out);
    end
  end

  // data captured in the wait cycle stands at the release edge
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      readdata_out <= 32'h0000_0000;
    end else if (read_in && waitrequest_out) begin
      readdata_out <= {24'h00_0000, next_rdata};
    end
  end

endmodule : mrsc_reset_ctrl

// file: mrsc_sva.sv
`timescale 1ns/10ps
// **********
// port checker for the reset controller
// **********
module mrsc_checker (
  input wire logic        sys_clk_in,
  input wire logic        rstn_in,
  input wire logic [3:0]  address_in,
  input wire logic        read_in,
  input wire logic        wdt_timeout_in,
  input wire logic        sleep_in,
  input wire logic        idle_in,
  input wire logic        powerdown_in,
  input wire logic [31:0] readdata_out,
  input wire logic        waitrequest_out,
  input wire logic        core_rst_n_out,
  input wire logic        por_init_out,
  input wire logic        pc_sp_clear_out,
  input wire logic [7:0]  port_init_out,
  input wire logic [7:0]  analog_assign_out,
  input wire logic        brownout_monitor_en_out,
  input wire logic        timeout_status_flag_out,
  input wire logic        powerdown_status_flag_out
);
  // one clock domain
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  // cause pad bits read zero
  property p_pad;
    !waitrequest_out && read_in && address_in == 4'h4 |-> readdata_out[6:3] == 4'h0;
  endproperty
  a_pad: assert property (p_pad) else $error("cause pad bits nonzero");
  // monitor off a cycle after power-down
  property p_mon;
    powerdown_in |=> !brownout_monitor_en_out;
  endproperty
  a_mon: assert property (p_mon) else $error("monitor on in power-down");
  // running overflow: full reset, flag
  property p_norm;
    wdt_timeout_in && !sleep_in && !idle_in && core_rst_n_out
      |=> !core_rst_n_out ##1 timeout_status_flag_out;
  endproperty
  a_norm: assert property (p_norm) else $error("normal overflow reset wrong");
  // asleep overflow: light clear, flags
  property p_sleep;
    wdt_timeout_in && (sleep_in || idle_in) && core_rst_n_out
      |=> pc_sp_clear_out && core_rst_n_out ##1 timeout_status_flag_out && powerdown_status_flag_out;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep overflow wrong");
  // a core reset is never a glitch
  property p_hold;
    $fell(core_rst_n_out) |=> !core_rst_n_out [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("core reset too short");
  // pins preset in power-on phase
  property p_preset;
    por_init_out |-> port_init_out == 8'hff && analog_assign_out == 8'hff;
  endproperty
  a_preset: assert property (p_preset) else $error("port preset missing");
  // power-on phase ends after release
  property p_por_end;
    $rose(core_rst_n_out) && por_init_out |=> !por_init_out;
  endproperty
  a_por_end: assert property (p_por_end) else $error("power-on phase late");
  // only power-on clears flags
  property p_sticky;
    !$fell(timeout_status_flag_out) && !$fell(powerdown_status_flag_out);
  endproperty
  a_sticky: assert property (p_sticky) else $error("status flag cleared");
endmodule : mrsc_checker

// file: mrsc_far_model.sv
`timescale 1ns/10ps
// **********
// far side: core, supply detector, watchdog
// **********
module mrsc_far_model (
  input  wire logic sys_clk_in,
  output logic      slow_osc_out,     // low-speed oscillator
  output logic      low_supply_out,   // high = supply low
  output logic      wdt_timeout_out,  // overflow pulse
  output logic      sleep_out,
  output logic      idle_out,
  output logic      powerdown_out
);
  initial begin
    slow_osc_out    = 1'b0;
    low_supply_out  = 1'b0;
    wdt_timeout_out = 1'b0;
    sleep_out       = 1'b0;
    idle_out        = 1'b0;
    powerdown_out   = 1'b0;
  end
  // free-running, unrelated to sys_clk_in
  always #155.3 slow_osc_out = ~slow_osc_out;
  // level changes after an edge
  task automatic set_low(input logic v);
    @(posedge sys_clk_in);
    low_supply_out <= v;
  endtask : set_low
  // core mode levels
  task automatic set_mode(input logic s, input logic i, input logic p);
    @(posedge sys_clk_in);
    sleep_out     <= s;
    idle_out      <= i;
    powerdown_out <= p;
  endtask : set_mode
  // one-cycle overflow pulse
  task automatic fire_wdt;
    @(posedge sys_clk_in);
    wdt_timeout_out <= 1'b1;
    @(posedge sys_clk_in);
    wdt_timeout_out <= 1'b0;
  endtask : fire_wdt
endmodule : mrsc_far_model

// file: mrsc_reset_ctrl_tb.sv
`timescale 1ns/10ps
module mrsc_reset_ctrl_tb;
  // **********
  // signals
  // **********
  localparam int unsigned LOW_MIN = 20;  // brief run
  logic        sys_clk_in    = 1'b0;
  logic        rstn_in       = 1'b0;
  logic [3:0]  address_in    = 4'h0;
  logic        read_in       = 1'b0;
  logic        write_in      = 1'b0;
  logic [31:0] writedata_in  = 32'h0000_0000;
  logic [3:0]  byteenable_in;  // lane 0 only
  logic        slow_osc_in, low_supply_in, wdt_timeout_in, sleep_in, idle_in, powerdown_in;
  logic [31:0] readdata_out;
  logic        waitrequest_out, core_rst_n_out, por_init_out, pc_sp_clear_out, wdt_clear_out;
  logic [7:0]  port_init_out, analog_assign_out, threshold_select_out;
  logic [4:0]  watchdog_enable_out;
  logic        brownout_monitor_en_out, idle_sysclk_keep_out;
  logic        timeout_status_flag_out, powerdown_status_flag_out;
  int          num_errors = 0;
  int          tests_run  = 0;
  logic [7:0]  codes [4]  = '{8'h55, 8'h33, 8'h99, 8'haa};  // legal thresholds
  always #5 sys_clk_in = ~sys_clk_in;
  mrsc_far_model far (.sys_clk_in, .slow_osc_out(slow_osc_in), .low_supply_out(low_supply_in),
    .wdt_timeout_out(wdt_timeout_in), .sleep_out(sleep_in), .idle_out(idle_in),
    .powerdown_out(powerdown_in));
  mrsc_reset_ctrl #(.LOW_SUPPLY_MIN_CYCLES(LOW_MIN)) DUT (.sys_clk_in, .rstn_in, .slow_osc_in,
    .low_supply_in, .wdt_timeout_in, .sleep_in, .idle_in, .powerdown_in, .address_in, .read_in,
    .write_in, .writedata_in, .byteenable_in, .readdata_out, .waitrequest_out, .core_rst_n_out,
    .por_init_out, .pc_sp_clear_out, .wdt_clear_out, .port_init_out, .analog_assign_out,
    .brownout_monitor_en_out, .threshold_select_out, .watchdog_enable_out,
    .idle_sysclk_keep_out, .timeout_status_flag_out, .powerdown_status_flag_out);
  // **********
  // tasks
  // **********
  task automatic summarize;
    if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one avalon transfer
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge sys_clk_in);
    address_in   <= a;
    write_in     <= wr;
    read_in      <= !wr;
    writedata_in <= {24'h00_0000, d};
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (waitrequest_out !== 1'b0 && n < 50);
    if (n >= 50) begin
      num_errors++;
      summarize();
    end
    q = readdata_out;
    read_in  <= 1'b0;
    write_in <= 1'b0;
  endtask : bus
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  // upper bits read zero
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, {24'h00_0000, exp});
  endtask : rd
  // reset falls in lo..hi cycles; 500 = none
  task automatic wait_rst(input int lo, input int hi);
    int n;
    n = 0;
    while (core_rst_n_out !== 1'b0 && n < 500) begin
      @(posedge sys_clk_in);
      n++;
    end
    chk(32'(n >= lo && n <= hi), 32'h0000_0001);
    n = 0;
    while (core_rst_n_out !== 1'b1 && n < 500) begin
      @(posedge sys_clk_in);
      n++;
    end
    if (n >= 500) begin
      num_errors++;
      summarize();
    end
    if (lo < 500) chk(32'(n >= 95 && n <= 110), 32'h0000_0001);
  endtask : wait_rst
  // **********
  // sequence
  // **********
  initial begin
    byteenable_in <= 4'h1;
    repeat (8) @(posedge sys_clk_in);
    chk({8'h00, port_init_out, analog_assign_out, 7'h00, por_init_out}, 32'h00ff_ff01);
    rstn_in <= 1'b1;
    wait_rst(0, 2);
    repeat (2) @(posedge sys_clk_in);
    chk({14'h0000, port_init_out, analog_assign_out, por_init_out, wdt_clear_out}, 32'h0000_0000);
    rd(4'h0, 8'h55);
    byteenable_in <= 4'h0;
    wr(4'h0, 8'h33);
    byteenable_in <= 4'h1;
    rd(4'h0, 8'h55);
    rd(4'h4, 8'h00);
    rd(4'h8, 8'h00);
    wr(4'h8, 8'hff);
    rd(4'h8, 8'h00);
    rd(4'h2, 8'h00);
    wr(4'h4, 8'hff);
    rd(4'h4, 8'h80);
    wr(4'h4, 8'h00);
    foreach (codes[i]) begin
      wr(4'h0, codes[i]);
      rd(4'h0, codes[i]);
    end
    wait_rst(500, 500);
    // illegal threshold and watchdog codes
    wr(4'h0, 8'h12);
    wait_rst(55, 100);
    rd(4'h0, 8'h55);
    rd(4'h4, 8'h02);
    wr(4'h4, 8'h00);
    rd(4'h4, 8'h00);
    wr(4'hc, 8'h03);
    wait_rst(55, 100);
    rd(4'hc, 8'h0a);
    // real low supply
    wr(4'h0, 8'h99);
    far.set_low(1'b1);
    repeat (30) @(posedge sys_clk_in);
    far.set_low(1'b0);
    wait_rst(50, 95);
    rd(4'h0, 8'h99);
    rd(4'h4, 8'h05);
    rd(4'h8, 8'h00);
    far.set_low(1'b1);
    repeat (10) @(posedge sys_clk_in);
    far.set_low(1'b0);
    wait_rst(500, 500);
    far.set_mode(1'b0, 1'b0, 1'b1);
    far.set_low(1'b1);
    wait_rst(500, 500);
    far.set_low(1'b0);
    far.set_mode(1'b0, 1'b0, 1'b0);
    wr(4'h4, 8'h00);
    rd(4'h4, 8'h00);
    far.fire_wdt();
    wait_rst(0, 3);
    rd(4'h8, 8'h02);
    for (int m = 0; m < 2; m++) begin
      far.set_mode(m == 0, m == 1, 1'b0);
      far.fire_wdt();
      wait_rst(500, 500);
      rd(4'h8, 8'h03);
    end
    far.set_mode(1'b0, 1'b0, 1'b0);
    // second power-on in mid-run
    rstn_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    wait_rst(0, 2);
    rd(4'h8, 8'h00);
    rd(4'h0, 8'h55);
    summarize();
  end
endmodule : mrsc_reset_ctrl_tb
bind mrsc_reset_ctrl mrsc_checker u_chk (.*);
